/* File: logic/audio_routing_pkg.sv */
// Shared constants and types for the audio routing matrix
package audio_routing_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_IN_FMT     = 16'he000;
  localparam logic [15:0] IDX_ALLOC_STAT = 16'he001;
  localparam logic [15:0] IDX_OUT_MODE   = 16'he040;
  localparam logic [15:0] IDX_HS_SLAVE   = 16'he049;
  localparam logic [15:0] IDX_CONV_SEL0  = 16'he080;
  localparam int          ADDR_W         = 20;

  // Field positions of the output mode and high-speed slave words, and field widths
  localparam int BCLK_POL_BIT = 9;
  localparam int FCLK_POL_BIT = 8;
  localparam int WL_LSB       = 6;
  localparam int MSB_POS_LSB  = 3;
  localparam int CH_LSB       = 0;
  localparam int HS_BIT       = 0;
  localparam int FMT_W        = 3;
  localparam int SEL_W        = 6;

  // Reset values
  localparam logic [15:0] RESET_OUT_MODE = 16'h0000;
  localparam logic [26:0] RESET_IN_FMT   = 27'h0000000;
  localparam logic [5:0]  RESET_CONV_SEL = 6'h3f;
  localparam logic        RESET_HS       = 1'b0;

  // Fabric dimensions
  localparam int IN_PORTS   = 9;
  localparam int CHANNELS   = 24;
  localparam int CONV_PAIRS = 8;
  localparam int OUT_SLOTS  = 16;
  localparam int SAMPLE_W   = 24;

  // Source codes of the converter input selector
  localparam logic [5:0] SRC_SPDIF = 6'h0c;
  localparam logic [5:0] SRC_CORE0 = 6'h0d;
  localparam logic [5:0] SRC_LAST  = 6'h14;

  // Slot geometry in bit clocks
  localparam int SLOT_BCLKS        = 32;
  localparam int PACKED_SLOT_BCLKS = 24;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WL_24   = 2'h0,
    WL_20   = 2'h1,
    WL_16   = 2'h2,
    WL_FLEX = 2'h3
  } word_len_e;

  typedef enum logic [2:0] {
    CH_2       = 3'h0,
    CH_4       = 3'h1,
    CH_8       = 3'h2,
    CH_16      = 3'h3,
    CH_PACKED4 = 3'h4
  } chan_fmt_e;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_e;

endpackage : audio_routing_pkg

/* File: logic/audio_routing_matrix.sv */
// Audio routing matrix: channel allocation, converter input fabric, output framer
// Notes on behaviour
// RQ1 - Bit clock polarity picks the edge on which frame clock and data change.
// RQ2 - Frame clock polarity picks which frame clock edge starts the left channel.
// RQ3 - Slots reserve 24 bits; shorter word lengths pad trailing bits with zeros.
// RQ4 - Software sets word length 11 and channel code 010 together for flexible TDM.
// RQ5 - Channel code selects two, four, eight or flexible, sixteen, or packed four.
// RQ6 - MSB position codes 000 to 100 delay first bit 1, 0, 8, 12, 16 clocks.
// RQ7 - Software sets high-speed slave bit above 22 MHz bit clock; resets disabled.
// RQ8 - Fabric switches stereo pairs only; each destination takes at most one source.
// RQ9 - Pass-through latency is several sample periods and grows with added stages.
// RQ10 - Nine input ports feed 24 routing channels, twelve stereo pairs.
// RQ11 - Channels are allocated in ascending port order, contiguous blocks per format.
// RQ12 - Allocation depends only on configured format, even for disconnected pins.
// RQ13 - Allocated channels go to core inputs and to the converter input fabric.
// RQ14 - Each converter pair selects one of 21 sources: 12 inputs, receiver, 8 core.
// RQ15 - Two-group variant: sources for pairs 0-3 and 4-7 are mutually synchronous.
// RQ16 - Without converters, inputs go straight to core; fabric stays unused.
// RQ17 - Software routes inputs asynchronous to the core through a converter first.
// RQ18 - Software should set converter target rate synchronous to the core rate.
// RQ19 - Core-to-converter pairs may be converted and go to the output fabric.
// RQ20 - Converter outputs go to core inputs and output fabric without selection.
// RQ21 - Reserved bits of the high-speed slave register read zero, ignore writes.
`timescale 1ns/1ps

module audio_routing_matrix #(
  parameter int CONVERTERS = 1  // 0 none, 1 eight independent, 2 two groups
) (
  // Clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    srst_in,
  // AXI4-Lite slave
  input  wire logic [19:0]             s_axi_awaddr_in,
  input  wire logic                    s_axi_awvalid_in,
  output logic                         s_axi_awready_out,
  input  wire logic [31:0]             s_axi_wdata_in,
  input  wire logic [3:0]              s_axi_wstrb_in,
  input  wire logic                    s_axi_wvalid_in,
  output logic                         s_axi_wready_out,
  output logic [1:0]                   s_axi_bresp_out,
  output logic                         s_axi_bvalid_out,
  input  wire logic                    s_axi_bready_in,
  input  wire logic [19:0]             s_axi_araddr_in,
  input  wire logic                    s_axi_arvalid_in,
  output logic                         s_axi_arready_out,
  output logic [31:0]                  s_axi_rdata_out,
  output logic [1:0]                   s_axi_rresp_out,
  output logic                         s_axi_rvalid_out,
  input  wire logic                    s_axi_rready_in,
  // Deserialised words from the serial input receivers
  input  wire logic                    in_word_valid_in,
  input  wire logic [3:0]              in_port_in,
  input  wire logic [3:0]              in_slot_in,
  input  wire logic [23:0]             in_word_in,
  input  wire logic                    core_sample_tick_in,
  // Other fabric sources
  input  wire logic [47:0]             spdif_pair_in,
  input  wire logic [7:0][47:0]        core_to_conv_in,
  input  wire logic [7:0][47:0]        conv_result_in,
  // Fabric results
  output logic [23:0][23:0]            core_channels_out,
  output logic [7:0][47:0]             conv_feed_out,
  output logic [7:0][47:0]             core_conv_out,
  output logic [7:0][47:0]             fabric_conv_out,
  output logic                         hs_slave_mode_out,
  // Serial output port, slave to external clocks
  input  wire logic                    out_bit_clock_in,
  input  wire logic                    out_frame_clock_in,
  input  wire logic [15:0][23:0]       out_slot_words_in,
  output logic                         out_serial_line_out
);

  // Elaboration check
  if (CONVERTERS < 0 || CONVERTERS > 2) begin : g_bad_conv
    $error("CONVERTERS must be 0, 1 or 2");
  end

  typedef struct packed {
    audio_routing_pkg::wr_state_e wr_state;
    logic                         aw_ready;
    logic                         w_ready;
    logic                         have_aw;
    logic                         have_w;
    logic [19:0]                  aw_addr;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic                         b_valid;
    logic [1:0]                   b_resp;
    logic                         ar_ready;
    logic                         r_valid;
    logic [31:0]                  r_data;
    logic [1:0]                   r_resp;
    logic                         rd_hs;
    logic [26:0]                  in_fmt;
    logic [15:0]                  out_mode;
    logic                         hs_mode;
    logic [7:0][5:0]              conv_sel;
    logic [23:0][23:0]            ch_stage;
    logic [23:0][23:0]            ch_core;
    logic [7:0][47:0]             conv_in;
    logic [7:0][47:0]             conv_out;
    logic [2:0]                   bclk_sync;
    logic [2:0]                   fclk_sync;
    logic                         fclk_prev;
    logic [8:0]                   bit_cnt;
    logic [15:0][23:0]            slot_words;
    logic                         serial_out;
  } state_s;

  state_s st;
  state_s next_s;

  // Channels carried by one port format
  function automatic logic [4:0] chan_count(input logic [2:0] code);
    case (code)
      audio_routing_pkg::CH_4:       chan_count = 5'h04;
      audio_routing_pkg::CH_8:       chan_count = 5'h08;
      audio_routing_pkg::CH_16:      chan_count = 5'h10;
      audio_routing_pkg::CH_PACKED4: chan_count = 5'h04;
      default:                       chan_count = 5'h02;
    endcase
  endfunction : chan_count

  // First channel of a port: sum of the blocks of all lower ports
  function automatic logic [7:0] port_base(input logic [26:0] fmt, input int port);
    logic [7:0] sum;
    sum = 8'h00;
    for (int p = 0; p < audio_routing_pkg::IN_PORTS; p++) begin
      if (p < port) begin
        sum = sum + {3'h0, chan_count(fmt[p*3 +: 3])};  // RQ11 RQ12
      end
    end
    port_base = sum;
  endfunction : port_base

  // Register index match on a word-aligned byte address
  function automatic logic reg_hit(input logic [19:0] addr, input logic [15:0] idx);
    reg_hit = (addr[19:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
  endfunction : reg_hit

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  // Output framing decode
  logic       flex_on;
  logic [4:0] wl_bits;
  logic [4:0] nch;
  logic [5:0] slot_len;
  logic [4:0] msb_delay;
  logic [7:0] alloc_total;
  logic       b_rise;
  logic       b_fall;
  logic       capture;
  logic       launch;
  logic       frame_start;
  logic [8:0] pos;
  logic [4:0] slot;
  logic [5:0] offs;
  logic       in_window;
  logic [4:0] bitp;
  logic [7:0] wr_ch;

  always_comb begin
    flex_on = (st.out_mode[7:6] == audio_routing_pkg::WL_FLEX)
           && (st.out_mode[2:0] == audio_routing_pkg::CH_8);  // RQ4
    case (st.out_mode[7:6])
      audio_routing_pkg::WL_20: wl_bits = 5'd20;  // RQ3
      audio_routing_pkg::WL_16: wl_bits = 5'd16;  // RQ3
      default:                  wl_bits = 5'd24;
    endcase
    nch = flex_on ? 5'd8 : chan_count(st.out_mode[2:0]);  // RQ5
    slot_len = (st.out_mode[2:0] == audio_routing_pkg::CH_PACKED4)
             ? 6'(audio_routing_pkg::PACKED_SLOT_BCLKS) : 6'(audio_routing_pkg::SLOT_BCLKS);
    case (st.out_mode[5:3])
      3'h1:    msb_delay = 5'd0;  // RQ6
      3'h2:    msb_delay = 5'd8;
      3'h3:    msb_delay = 5'd12;
      3'h4:    msb_delay = 5'd16;
      default: msb_delay = 5'd1;
    endcase
    alloc_total = port_base(st.in_fmt, audio_routing_pkg::IN_PORTS);
  end

  // Bit clock edges and frame start on the launching edge
  always_comb begin
    b_rise = st.bclk_sync[1] & ~st.bclk_sync[2];
    b_fall = ~st.bclk_sync[1] & st.bclk_sync[2];
    capture = st.out_mode[audio_routing_pkg::BCLK_POL_BIT] ? b_fall : b_rise;
    launch = st.out_mode[audio_routing_pkg::BCLK_POL_BIT] ? b_rise : b_fall;  // RQ1
    frame_start = launch && (st.fclk_sync[1] != st.fclk_prev)
               && (st.fclk_sync[1] == st.out_mode[audio_routing_pkg::FCLK_POL_BIT]);  // RQ2
    pos = frame_start ? 9'h000 : ((st.bit_cnt == 9'h1ff) ? st.bit_cnt : st.bit_cnt + 9'h001);
    slot = 5'h00;
    offs = 6'h00;
    for (int i = 0; i < 21; i++) begin
      if ({3'h0, pos} >= 12'(i) * {6'h00, slot_len}) begin
        slot = 5'(i);
        offs = 6'({3'h0, pos} - 12'(i) * {6'h00, slot_len});
      end
    end
    in_window = (offs >= {1'b0, msb_delay}) && (offs - {1'b0, msb_delay} < 6'd24)
             && (slot < nch);
    bitp = 5'(offs - {1'b0, msb_delay});
    wr_ch = port_base(st.in_fmt, int'(in_port_in)) + {4'h0, in_slot_in};
  end

  // Next-state logic
  always_comb begin
    next_s = st;
    // Pin synchronisers
    next_s.bclk_sync = {st.bclk_sync[1:0], out_bit_clock_in};
    next_s.fclk_sync = {st.fclk_sync[1:0], out_frame_clock_in};

    // Write channel
    case (st.wr_state)
      audio_routing_pkg::WR_COLLECT: begin
        if (s_axi_awvalid_in && st.aw_ready) begin
          next_s.have_aw  = 1'b1;
          next_s.aw_addr  = s_axi_awaddr_in;
          next_s.aw_ready = 1'b0;
        end
        if (s_axi_wvalid_in && st.w_ready) begin
          next_s.have_w  = 1'b1;
          next_s.w_data  = s_axi_wdata_in;
          next_s.w_strb  = s_axi_wstrb_in;
          next_s.w_ready = 1'b0;
        end
        if (st.have_aw && st.have_w) begin
          next_s.b_resp = audio_routing_pkg::RESP_OKAY;
          if (reg_hit(st.aw_addr, audio_routing_pkg::IDX_IN_FMT)) begin
            next_s.in_fmt = 27'(merge({5'h00, st.in_fmt}, st.w_data, st.w_strb));
          end else if (reg_hit(st.aw_addr, audio_routing_pkg::IDX_OUT_MODE)) begin
            next_s.out_mode = 16'(merge({16'h0000, st.out_mode}, st.w_data, st.w_strb));
          end else if (reg_hit(st.aw_addr, audio_routing_pkg::IDX_HS_SLAVE)) begin
            if (st.w_strb[0]) begin
              next_s.hs_mode = st.w_data[audio_routing_pkg::HS_BIT];  // RQ7 RQ21
            end
          end else if (reg_hit(st.aw_addr, audio_routing_pkg::IDX_ALLOC_STAT)) begin
            next_s.b_resp = audio_routing_pkg::RESP_OKAY;  // Read-only, write ignored
          end else if (st.aw_addr[19:5] == {2'h0, audio_routing_pkg::IDX_CONV_SEL0[15:3]}) begin
            for (int k = 0; k < audio_routing_pkg::CONV_PAIRS; k++) begin
              if (reg_hit(st.aw_addr, audio_routing_pkg::IDX_CONV_SEL0 + 16'(k))
                  && st.w_strb[0]) begin
                next_s.conv_sel[k] = st.w_data[5:0];
              end
            end
          end else begin
            next_s.b_resp = audio_routing_pkg::RESP_SLVERR;
          end
          next_s.have_aw  = 1'b0;
          next_s.have_w   = 1'b0;
          next_s.b_valid  = 1'b1;
          next_s.wr_state = audio_routing_pkg::WR_RESP;
        end
      end
      audio_routing_pkg::WR_RESP: begin
        if (s_axi_bready_in) begin
          next_s.b_valid  = 1'b0;
          next_s.aw_ready = 1'b1;
          next_s.w_ready  = 1'b1;
          next_s.wr_state = audio_routing_pkg::WR_COLLECT;
        end
      end
      default: next_s.wr_state = audio_routing_pkg::WR_COLLECT;
    endcase

    // Read channel
    if (st.r_valid && s_axi_rready_in) begin
      next_s.r_valid  = 1'b0;
      next_s.ar_ready = 1'b1;
    end else if (s_axi_arvalid_in && st.ar_ready) begin
      next_s.r_valid  = 1'b1;
      next_s.ar_ready = 1'b0;
      next_s.r_resp   = audio_routing_pkg::RESP_OKAY;
      next_s.r_data   = 32'h00000000;
      next_s.rd_hs    = 1'b0;
      if (reg_hit(s_axi_araddr_in, audio_routing_pkg::IDX_IN_FMT)) begin
        next_s.r_data = {5'h00, st.in_fmt};
      end else if (reg_hit(s_axi_araddr_in, audio_routing_pkg::IDX_ALLOC_STAT)) begin
        next_s.r_data = {23'h000000, (alloc_total > 8'd24), alloc_total};
      end else if (reg_hit(s_axi_araddr_in, audio_routing_pkg::IDX_OUT_MODE)) begin
        next_s.r_data = {16'h0000, st.out_mode};
      end else if (reg_hit(s_axi_araddr_in, audio_routing_pkg::IDX_HS_SLAVE)) begin
        next_s.r_data = {31'h00000000, st.hs_mode};  // RQ21
        next_s.rd_hs  = 1'b1;
      end else if (s_axi_araddr_in[19:5] == {2'h0, audio_routing_pkg::IDX_CONV_SEL0[15:3]}
                   && s_axi_araddr_in[1:0] == 2'h0) begin
        next_s.r_data = {26'h0000000, st.conv_sel[s_axi_araddr_in[4:2]]};
      end else begin
        next_s.r_resp = audio_routing_pkg::RESP_SLVERR;
      end
    end

    // Channel allocation into the 24-channel staging array
    if (in_word_valid_in && in_port_in < 4'(audio_routing_pkg::IN_PORTS)
        && {1'b0, in_slot_in} < chan_count(st.in_fmt[in_port_in*3 +: 3])
        && wr_ch < 8'(audio_routing_pkg::CHANNELS)) begin
      next_s.ch_stage[wr_ch[4:0]] = in_word_in;  // RQ10 RQ11 RQ12
    end
    // Core takes a full channel set once per core sample
    if (core_sample_tick_in) begin
      next_s.ch_core = st.ch_stage;  // RQ9 RQ13 RQ16
    end

    // Converter input fabric, one source per destination pair
    for (int k = 0; k < audio_routing_pkg::CONV_PAIRS; k++) begin
      next_s.conv_in[k] = 48'h000000000000;
      if (CONVERTERS != 0) begin
        if (st.conv_sel[k] < audio_routing_pkg::SRC_SPDIF) begin
          next_s.conv_in[k] = {st.ch_core[st.conv_sel[k]*2+1], st.ch_core[st.conv_sel[k]*2]};
        end else if (st.conv_sel[k] == audio_routing_pkg::SRC_SPDIF) begin
          next_s.conv_in[k] = spdif_pair_in;  // RQ14
        end else if (st.conv_sel[k] <= audio_routing_pkg::SRC_LAST) begin
          next_s.conv_in[k] = core_to_conv_in[st.conv_sel[k] - audio_routing_pkg::SRC_CORE0];
        end
      end
    end  // RQ8 RQ13 RQ14 RQ19
    next_s.conv_out = (CONVERTERS != 0) ? conv_result_in : '0;  // RQ20

    // Frame clock level taken on the capture edge, where it stands still
    if (capture) begin
      next_s.fclk_prev = st.fclk_sync[1];  // RQ2
    end
    // Output framer, advanced only on the launching bit clock edge
    if (launch) begin
      next_s.bit_cnt   = pos;
      if (frame_start) begin
        next_s.slot_words = out_slot_words_in;  // RQ9
      end
      next_s.serial_out = 1'b0;
      if (in_window && bitp < wl_bits) begin
        next_s.serial_out = next_s.slot_words[slot[3:0]][5'd23 - bitp];  // RQ3 RQ6
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st          <= '0;
      st.wr_state <= audio_routing_pkg::WR_COLLECT;
      st.aw_ready <= 1'b1;
      st.w_ready  <= 1'b1;
      st.ar_ready <= 1'b1;
      st.in_fmt   <= audio_routing_pkg::RESET_IN_FMT;
      st.out_mode <= audio_routing_pkg::RESET_OUT_MODE;
      st.hs_mode  <= audio_routing_pkg::RESET_HS;  // RQ7
      st.conv_sel <= {8{audio_routing_pkg::RESET_CONV_SEL}};
    end else begin
      st <= next_s;
    end
  end

  // Outputs straight from state
  assign s_axi_awready_out   = st.aw_ready;
  assign s_axi_wready_out    = st.w_ready;
  assign s_axi_bvalid_out    = st.b_valid;
  assign s_axi_bresp_out     = st.b_resp;
  assign s_axi_arready_out   = st.ar_ready;
  assign s_axi_rvalid_out    = st.r_valid;
  assign s_axi_rdata_out     = st.r_data;
  assign s_axi_rresp_out     = st.r_resp;
  assign core_channels_out   = st.ch_core;
  assign conv_feed_out       = st.conv_in;
  assign core_conv_out       = st.conv_out;
  assign fabric_conv_out     = st.conv_out;
  assign hs_slave_mode_out   = st.hs_mode;
  assign out_serial_line_out = st.serial_out;

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  sequence wr_pair_held;
    st.have_aw && st.have_w && st.wr_state == audio_routing_pkg::WR_COLLECT;
  endsequence
  sequence resp_waits;
    s_axi_bvalid_out && !s_axi_awready_out && !s_axi_wready_out;
  endsequence

  write_response_a: assert property (wr_pair_held |=> resp_waits)  // Write response follows a collected address and data pair
    else $error("write response missing");
  hs_reserved_a: assert property (s_axi_rvalid_out && st.rd_hs |-> s_axi_rdata_out[31:1] == 0)  // RQ21
    else $error("reserved high-speed bits not zero");
  launch_edge_a: assert property ($changed(out_serial_line_out) |-> $past(launch))  // RQ1
    else $error("serial data moved off the launching edge");
  zero_fill_a: assert property (launch && in_window && bitp >= wl_bits |=> !out_serial_line_out)  // RQ3
    else $error("trailing bit not zero");
  flex_pair_a: assert property (st.out_mode[7:6] == 2'h3 && st.out_mode[2:0] != 3'h2 |-> !flex_on)  // RQ4
    else $error("flexible mode on with one field only");
  frame_restart_a: assert property (  // RQ2
      frame_start |=> st.bit_cnt == 9'h000 && st.slot_words == $past(out_slot_words_in))
    else $error("frame start did not restart count");
  spdif_route_a: assert property (  // RQ14
      CONVERTERS != 0 && st.conv_sel[0] == 6'h0c |=> conv_feed_out[0] == $past(spdif_pair_in))
    else $error("receiver pair not routed");
  no_conv_a: assert property (CONVERTERS == 0 |-> conv_feed_out == '0 && core_conv_out == '0)  // RQ16
    else $error("fabric active without converters");
  conv_both_a: assert property (  // RQ20
      CONVERTERS != 0 |=> core_conv_out == $past(conv_result_in)
                          && fabric_conv_out == $past(conv_result_in))
    else $error("converter outputs disagree");
  core_tick_a: assert property (core_sample_tick_in |=> core_channels_out == $past(st.ch_stage))  // RQ13
    else $error("core channels not updated on tick");

endmodule : audio_routing_matrix

/* File: sim/codec_slave_model.sv */
// Behavioural external codec that clocks a serial output port as its slave
`timescale 1ns/1ps
module codec_slave_model (
  // Frame request and data from the port
  input  wire logic go_in,
  input  wire logic serial_in,
  // Clocks made here and the captured frame
  output logic        bit_clock_out,
  output logic        frame_clock_out,
  output logic [63:0] bits_out,
  output int          frames_out
);
  // Clocks stand still high between frames
  initial begin
    bit_clock_out = 1'b1;
    frame_clock_out = 1'b1;
    bits_out = '0;
    frames_out = 0;
  end
  // One frame per rise of go; 320 ns bit clock, slow enough for normal slave mode
  always @(posedge go_in) begin
    #10;  // Keep pin edges off the system clock edge
    for (int k = 0; k < 64; k++) begin
      bit_clock_out = 1'b0;
      frame_clock_out = (k >= 32);
      if (k > 0) bits_out[k - 1] = serial_in;
      #160 bit_clock_out = 1'b1;
      #160;
    end
    bits_out[63] = serial_in;
    frames_out++;
  end
endmodule : codec_slave_model

/* File: sim/audio_routing_matrix_tb.sv */
// Self-checking bench for the audio routing matrix
`timescale 1ns/1ps
module audio_routing_matrix_tb;
  localparam logic [1:0]  OK   = audio_routing_pkg::RESP_OKAY;
  localparam logic [15:0] HS   = audio_routing_pkg::IDX_HS_SLAVE;
  localparam logic [15:0] SEL  = audio_routing_pkg::IDX_CONV_SEL0;
  localparam logic [15:0] MODE = audio_routing_pkg::IDX_OUT_MODE;
  localparam logic [15:0] STAT = audio_routing_pkg::IDX_ALLOC_STAT;
  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [1:0]  rsp;
  } row_s;
  logic              clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0, wv = 1'b0, tick = 1'b0, go = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, hs, ser, bclk, fclk;
  logic [19:0]       awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic [1:0]        bresp, rresp;
  logic [3:0]        port = '0, slot = '0;
  logic [23:0]       word = '0;
  logic [47:0]       spdif = 48'h0a0b0c_0d0e0f;
  logic [7:0][47:0]  c2c = '0, cres = '0, feed, cconv, fconv;
  logic [23:0][23:0] chans;
  logic [15:0][23:0] slots = '0;
  logic [63:0]       bits;
  int                frames, n_mismatch = 0, comparisons = 0;
  // Register rows: written value beside the value read back
  row_s              rows [10] = '{
    '{HS, 32'hffffffff, 32'h1, OK}, '{HS, 32'h0, 32'h0, OK},
    '{MODE, 32'hffffffff, 32'hffff, OK}, '{STAT, 32'hffff, 32'h12, OK},
    '{SEL, 32'h0c, 32'h0c, OK}, '{SEL + 16'h1, 32'h0d, 32'h0d, OK},
    '{SEL + 16'h2, 32'h04, 32'h04, OK}, '{SEL + 16'h3, 32'h14, 32'h14, OK},
    '{SEL + 16'h4, 32'h15, 32'h15, OK}, '{16'he002, 32'h5, 32'h0, audio_routing_pkg::RESP_SLVERR}};
  // System clock, 40 ns period
  always #20 clk = ~clk;
  audio_routing_matrix u_dut (
    .clk_sys_in(clk), .srst_in(srst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .in_word_valid_in(wv), .in_port_in(port), .in_slot_in(slot), .in_word_in(word),
    .core_sample_tick_in(tick), .spdif_pair_in(spdif), .core_to_conv_in(c2c),
    .conv_result_in(cres), .core_channels_out(chans), .conv_feed_out(feed),
    .core_conv_out(cconv), .fabric_conv_out(fconv), .hs_slave_mode_out(hs),
    .out_bit_clock_in(bclk), .out_frame_clock_in(fclk), .out_slot_words_in(slots),
    .out_serial_line_out(ser));
  codec_slave_model u_codec (.go_in(go), .serial_in(ser), .bit_clock_out(bclk),
    .frame_clock_out(fclk), .bits_out(bits), .frames_out(frames));
  task automatic end_sim();
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [47:0] g, input logic [47:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      chk("wait", 48'h0, 48'h1);
      end_sim();
    end
  endtask : tmo
  task automatic axw(input logic [15:0] i, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= 20'(i * 4);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 60 && bvalid !== 1'b1; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    tmo(n, 60);
    bready <= 1'b0;
    chk("bresp", 48'(bresp), 48'(er));
  endtask : axw
  task automatic axr(input logic [15:0] i, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= 20'(i * 4);
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 60 && rvalid !== 1'b1; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    tmo(n, 60);
    rready <= 1'b0;
    chk("rdata", 48'(rdata), 48'(e));
    chk("rresp", 48'(rresp), 48'(er));
  endtask : axr
  task automatic put(input int p, input int s, input int w);
    @(posedge clk);
    wv <= 1'b1;
    port <= 4'(p);
    slot <= 4'(s);
    word <= 24'(w);
    @(posedge clk);
    wv <= 1'b0;
  endtask : put
  task automatic frame(input logic [31:0] m, input int wl, input int dly);
    int n, o, f0;
    logic e;
    axw(MODE, m, OK);
    f0 = frames;
    go <= 1'b1;
    for (n = 0; n < 900 && frames == f0; n++) @(posedge clk);
    tmo(n, 900);
    go <= 1'b0;
    for (int k = 0; k < 64; k++) begin
      o = k % 32 - dly;
      e = (o >= 0 && o < wl) ? slots[k / 32][23 - o] : 1'b0;
      chk("serial bit", 48'(bits[k]), 48'(e));
    end
  endtask : frame
  // Main sequence
  initial begin
    c2c[0] = 48'h111111_222222;
    c2c[7] = 48'h777777_888888;
    cres[3] = 48'h333333_444444;
    slots[0] = 24'ha5c3f1;
    slots[1] = 24'h5a3c0f;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    axr(HS, 32'h0, OK);
    axr(SEL + 16'h5, 32'h3f, OK);
    foreach (rows[i]) begin
      axw(rows[i].idx, rows[i].wd, rows[i].rsp);
      axr(rows[i].idx, rows[i].rd, rows[i].rsp);
    end
    // Ports take 2, 8, 4 channels, the rest 2 each; total 26
    axw(audio_routing_pkg::IDX_IN_FMT, 32'h50, OK);
    axr(STAT, 32'h11a, OK);
    put(0, 1, 1);
    put(1, 7, 9);
    put(2, 0, 10);
    put(2, 3, 13);
    put(4, 1, 17);
    put(1, 8, 'h0bad01);
    put(8, 0, 'h0bad02);
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (3) @(posedge clk);
    // Port 3 sends nothing yet keeps its channels
    for (int c = 0; c < 24; c++) begin
      chk("channel", 48'(chans[c]), (c inside {1, 9, 10, 13, 17}) ? 48'(c) : 48'h0);
    end
    chk("feed0", feed[0], spdif);
    chk("feed1", feed[1], c2c[0]);
    chk("feed2", feed[2], {24'h9, 24'h0});
    chk("feed3", feed[3], c2c[7]);
    chk("feed4", feed[4], 48'h0);
    chk("to core", cconv[3], cres[3]);
    chk("to fabric", fconv[3], cres[3]);
    frame(32'h0, 24, 1);
    frame(32'h88, 16, 0);
    frame(32'hc0, 24, 1);
    axw(HS, 32'h1, OK);
    chk("hs mode", 48'(hs), 48'h1);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    axr(HS, 32'h0, OK);
    chk("hs mode", 48'(hs), 48'h0);
    end_sim();
  end
endmodule : audio_routing_matrix_tb
